// >>> hw/main_div_pkg.sv
// package for the main pulse-swallow feedback divider
package main_div_pkg;
    localparam int WORD_W = 18;
    localparam logic [1:0] SEL_MAIN_N = 2'h3;
    localparam int SEL_LSB = 0;
    localparam int SWALLOW_LSB = 2;
    localparam int PROG_MSB = 17;
    localparam int SWALLOW_W_HI = 5;
    localparam int SWALLOW_W_LO = 4;
    localparam int COUNT_W = 12;
    localparam logic [WORD_W-1:0] LATCH_RESET = 18'h0_0000;
    localparam logic [COUNT_W-1:0] PROG_RESET = 12'h003;
    localparam logic [1:0] OPT_P32 = 2'h0;
    localparam logic [1:0] OPT_P16 = 2'h1;
    localparam logic [1:0] OPT_P8 = 2'h2;
    localparam int SYNC_STAGES = 3;

    typedef struct packed {
        logic [COUNT_W-1:0] prog;
        logic [COUNT_W-1:0] swallow;
    } ratio_t;
endpackage : main_div_pkg

// >>> hw/main_pulse_swallow_divider.sv
// main-loop pulse-swallow feedback divider with serial latch
//
// Operation
// - latch strobe rise with control bits 1 1 copies the word into the latch
// - feedback ratio is sixteen bits, continuous 992 or 240 up to 65535
// - swallow five bits and programmable eleven, or four and twelve bits
// - programmable count on top, swallow down to bit 2, control in bits 1:0
// - swallow count is plain binary, 0..31 or 0..15
// - modulus high for A prescaler outputs, then low for B minus A
// - total ratio equals P times programmable count plus swallow count
// - prescaler modulus is 32, 16 or 8, alternate is P plus one
// - with 8/9 prescaler the ratio is continuous from 56 to 32775
// - serial bits enter on shift clock rise, most significant bit first
`timescale 1ns/1ps
module main_pulse_swallow_divider (
    input wire logic ref_clk, // system clock, 100 MHz
    input wire logic reset_n, // synchronous reset, active low
    input wire logic [1:0] prescaler_option, // 0: 32/33, 1: 16/17, 2: 8/9
    input wire logic shift_clk, // serial shift clock pin
    input wire logic shift_data, // serial data pin
    input wire logic latch_strobe, // latch enable pin
    input wire logic prescaler_out, // prescaled vco pulse train
    output logic modulus_high, // high: prescaler divides by P+1
    output logic divider_out, // one pulse per feedback period
    output logic [17:0] latch_word // latched main word
);
    ////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages per pin, a level change counts once stages 2 and 3 agree
    // the agreement filter costs no latency but keeps a one-cycle glitch out of the counters
    logic [3:0] pin_raw;
    wire logic [3:0] pin_level;
    wire logic [3:0] pin_rise;
    logic sck_rise, strobe_rise, pre_rise, sdi_level;

    assign pin_raw = {prescaler_out, latch_strobe, shift_data, shift_clk};

    for (genvar gi = 0; gi < 4; gi++) begin : sync_g
        logic [main_div_pkg::SYNC_STAGES-1:0] stage_q, stage_d;
        logic level_q, level_d;

        always_comb begin
            stage_d = {stage_q[1:0], pin_raw[gi]};
            level_d = level_q;
            if (stage_q[1] == stage_q[2]) begin
                level_d = stage_q[2];
            end
        end

        always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
                stage_q <= '0;
                level_q <= 1'b0;
            end else begin
                stage_q <= stage_d;
                level_q <= level_d;
            end
        end

        assign pin_level[gi] = level_q;
        assign pin_rise[gi] = level_d & ~level_q;

        filter_agree_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
            pin_rise[gi] |-> stage_q[1] && stage_q[2])
            else $error("pin edge taken before stages agreed");
    end

    // idle level of every pin is low, so reset leaves no false edge behind
    assign sck_rise = pin_rise[0];
    assign sdi_level = pin_level[1];
    assign strobe_rise = pin_rise[2];
    assign pre_rise = pin_rise[3];

    ////////////////////////////////////////////////////////////////
    // shift register and latch
    logic [17:0] shift_q, shift_d, latch_q, latch_d;
    logic load_q, load_d;

    always_comb begin
        shift_d = shift_q;
        latch_d = latch_q;
        load_d = 1'b0;
        if (sck_rise) begin
            shift_d = {shift_q[16:0], sdi_level};
        end
        if (strobe_rise && shift_q[1:0] == main_div_pkg::SEL_MAIN_N) begin
            latch_d = shift_q;
            load_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            shift_q <= main_div_pkg::LATCH_RESET;
            latch_q <= main_div_pkg::LATCH_RESET;
            load_q <= 1'b0;
        end else begin
            shift_q <= shift_d;
            latch_q <= latch_d;
            load_q <= load_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // field split per prescaler option
    main_div_pkg::ratio_t field;

    always_comb begin
        field.prog = '0;
        field.swallow = '0;
        if (prescaler_option == main_div_pkg::OPT_P32) begin
            field.prog = {1'b0, latch_q[17:7]};
            field.swallow = {7'h00, latch_q[6:2]};
        end else begin
            field.prog = latch_q[17:6];
            field.swallow = {8'h00, latch_q[5:2]};
        end
    end

    ////////////////////////////////////////////////////////////////
    // pulse-swallow counters: b counts every prescaler output, a the high-modulus ones
    // the P value itself lives in the external prescaler; only P+1/P is commanded here
    logic [11:0] b_q, b_d, a_q, a_d;
    main_div_pkg::ratio_t active_q, active_d;
    logic hi_q, hi_d, out_q, out_d;

    always_comb begin
        b_d = b_q;
        a_d = a_q;
        active_d = active_q;
        hi_d = hi_q;
        out_d = 1'b0;
        if (pre_rise) begin
            if (b_q <= 12'h001) begin
                // period ends: reload, picking up a new latch only here
                active_d = field;
                b_d = field.prog;
                a_d = field.swallow;
                hi_d = (field.swallow != 12'h000);
                out_d = 1'b1;
            end else begin
                b_d = b_q - 12'h001;
                if (a_q != 12'h000) begin
                    a_d = a_q - 12'h001;
                end
                hi_d = (a_q > 12'h001);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            b_q <= main_div_pkg::PROG_RESET;
            a_q <= 12'h000;
            active_q.prog <= main_div_pkg::PROG_RESET;
            active_q.swallow <= 12'h000;
            hi_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            b_q <= b_d;
            a_q <= a_d;
            active_q <= active_d;
            hi_q <= hi_d;
            out_q <= out_d;
        end
    end

    assign modulus_high = hi_q;
    assign divider_out = out_q;
    assign latch_word = latch_q;

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence strobe_main_s;
        strobe_rise && shift_q[1:0] == main_div_pkg::SEL_MAIN_N;
    endsequence

    sequence strobe_other_s;
        strobe_rise && shift_q[1:0] != main_div_pkg::SEL_MAIN_N;
    endsequence

    sequence reload_s;
        pre_rise && b_q <= 12'h001;
    endsequence

    sequence count_s;
        pre_rise && b_q > 12'h001;
    endsequence

    latch_copy_a: assert property (strobe_main_s |=> latch_q == $past(shift_q))
        else $error("latch did not take shift word");
    latch_hold_a: assert property (!(strobe_rise && shift_q[1:0] == main_div_pkg::SEL_MAIN_N) |=> $stable(latch_q))
        else $error("latch changed without strobe");
    shift_in_a: assert property (sck_rise |=> shift_q == {$past(shift_q[16:0]), $past(sdi_level)})
        else $error("serial bit not shifted in msb first");
    reload_val_a: assert property (pre_rise && b_q <= 12'h001 |=> b_q == $past(field.prog) && out_q)
        else $error("reload value wrong");
    count_down_a: assert property (pre_rise && b_q > 12'h001 |=> b_q == $past(b_q) - 12'h001)
        else $error("programmable count not decremented");
    no_early_a: assert property (pre_rise && b_q > 12'h001 |=> !out_q && active_q == $past(active_q))
        else $error("ratio changed mid period");
    high_span_a: assert property (pre_rise && b_q > 12'h001 |=> hi_q == ($past(a_q) > 12'h001))
        else $error("modulus control wrong");
    low_after_a: assert property (!hi_q && !(pre_rise && b_q <= 12'h001) |=> !hi_q)
        else $error("high modulus resumed mid period");
    field_hi_a: assert property (prescaler_option == 2'h0 |-> field.swallow[11:5] == 7'h00)
        else $error("swallow width wrong for 32/33");
    strobe_refused_a: assert property (strobe_other_s |=> $stable(latch_q))
        else $error("latch took a word meant for another register");
    reload_hi_a: assert property (reload_s |=> hi_q == ($past(field.swallow) != 12'h000))
        else $error("modulus control wrong at reload");
    pulse_single_a: assert property (out_q |=> !out_q)
        else $error("divider output wider than one cycle");
    swallow_done_a: assert property (count_s |=> a_q == ($past(a_q) == 12'h000 ? 12'h000 : $past(a_q) - 12'h001))
        else $error("swallow count not stepped down");
    swallow_lo_a: assert property (prescaler_option != main_div_pkg::OPT_P32 |-> field.swallow[11:4] == 8'h00)
        else $error("swallow width wrong for four-bit split");
    prog_lo_a: assert property (prescaler_option != main_div_pkg::OPT_P32 |-> field.prog == latch_q[17:6])
        else $error("programmable field misplaced for twelve-bit split");
endmodule : main_pulse_swallow_divider

// >>> tb/serial_host.sv
// host model driving the serial programming pins
`timescale 1ns/1ps
module serial_host (
    output logic shift_clk, // serial clock, still between words
    output logic shift_data, // serial data
    output logic latch_strobe // latch enable
);
    initial begin
        shift_clk = 1'b0;
        shift_data = 1'b0;
        latch_strobe = 1'b0;
    end
    task automatic send(input logic [17:0] w);
        for (int i = 17; i >= 0; i--) begin
            shift_data = w[i];
            #80 shift_clk = 1'b1;
            #80 shift_clk = 1'b0;
        end
        // hold time over: show the inverse, not a stale bit
        shift_data = ~w[0];
        #80 latch_strobe = 1'b1;
        #160 latch_strobe = 1'b0;
    endtask : send
endmodule : serial_host

// >>> tb/main_pulse_swallow_divider_bench.sv
// self-checking bench for the main pulse-swallow divider
`timescale 1ns/1ps
module main_pulse_swallow_divider_bench;
    logic ref_clk, reset_n, prescaler_out, modulus_high, divider_out, shift_clk, shift_data, latch_strobe;
    logic [1:0] prescaler_option;
    logic [17:0] latch_word, w;
    int errors = 0, n_checks = 0, seed = 65004, cyc = 0, rises = 0, highs = 0, pulses = -9, b, a, sw;
    main_pulse_swallow_divider dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .prescaler_option(prescaler_option),
        .shift_clk(shift_clk), .shift_data(shift_data), .latch_strobe(latch_strobe), .prescaler_out(prescaler_out),
        .modulus_high(modulus_high), .divider_out(divider_out), .latch_word(latch_word));
    serial_host host_u (.shift_clk(shift_clk), .shift_data(shift_data), .latch_strobe(latch_strobe));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic stop_test();
        if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    function automatic logic [17:0] word_of(input int pb, input int sa, input int swd);
        return 18'((pb << (swd + 2)) | (sa << 2) | 3);
    endfunction : word_of
    ///////////////////////////////////////////////////////////////
    // modulus seen just before a rise governs the output that rise ends
    always @(negedge ref_clk) begin
        cyc++;
        if (cyc > 40000) begin
            errors++;
            stop_test();
        end
        prescaler_out <= (cyc % 8) < 4;
        if (cyc % 8 == 0) begin
            rises++;
            highs += int'(modulus_high);
        end
        if (divider_out === 1'b1) begin
            if (pulses >= 1) begin
                check("programmable_count", 18'(b), 18'(rises));
                check("swallow_count", 18'(a), 18'(highs));
            end
            pulses++;
            rises = 0;
            highs = 0;
        end
    end
    initial begin
        reset_n = 1'b0;
        prescaler_option = main_div_pkg::OPT_P32;
        repeat (20) @(negedge ref_clk);
        reset_n = 1'b1;
        @(negedge ref_clk);
        check("latch_word", main_div_pkg::LATCH_RESET, latch_word);
        for (int opt = 0; opt < 3; opt++) begin
            @(negedge ref_clk) reset_n = 1'b0;
            // no period checks until the new word has been loaded
            pulses = -100000;
            prescaler_option = 2'(opt);
            sw = (opt == 0) ? main_div_pkg::SWALLOW_W_HI : main_div_pkg::SWALLOW_W_LO;
            repeat (2) @(negedge ref_clk);
            reset_n = 1'b1;
            check("latch_word", main_div_pkg::LATCH_RESET, latch_word);
            check("modulus_high", 18'h0_0000, 18'(modulus_high));
            check("divider_out", 18'h0_0000, 18'(divider_out));
            for (int k = 0; k < 3; k++) begin
                // corners: smallest count, swallow equal to count at its top, then random
                a = (k == 1) ? (1 << sw) - 1 : 0;
                b = (k == 0) ? 3 : a;
                if (k == 2) begin
                    b = 3 + {$random(seed)} % 40;
                    a = {$random(seed)} % ((b < (1 << sw)) ? b + 1 : 1 << sw);
                end
                w = word_of(b, a, sw);
                pulses = -100000;
                host_u.send(w);
                check("latch_word", w, latch_word);
                host_u.send({16'($random(seed)), 2'(k)});
                check("latch_word", w, latch_word);
                pulses = 0;
                wait (pulses >= 3);
            end
        end
        stop_test();
    end
endmodule : main_pulse_swallow_divider_bench
